/* scs_pkg.sv */
`default_nettype none
package scs_pkg;
  // Network dimensions
  localparam int NUM_SRC = 8;
  localparam int NUM_PAD = 6;
  localparam int NUM_ROUTED = 2;
  localparam int NUM_REGION = 20;
  localparam int NUM_SLICE = 3;
  localparam int NUM_PRIMARY = 8;
  localparam int NUM_CLK_LINE = 7;
  localparam int NUM_CTL_LINE = 5;
  // Slice clock select codes
  localparam logic [4:0] CLK_SEL_NONE = 5'h00;
  localparam logic [4:0] CLK_SEL_PRI0 = 5'h01;
  localparam logic [4:0] CLK_SEL_SEC0 = 5'h09;
  localparam logic [4:0] CLK_SEL_ROUTE = 5'h10;
  // Slice control select codes
  localparam logic [2:0] CTL_SEL_NONE = 3'h0;
  localparam logic [2:0] CTL_SEL_SEC0 = 3'h1;
  localparam logic [2:0] CTL_SEL_ROUTE = 3'h6;
  // Secondary lines that reach the clock mux, entry 0 in low bits
  localparam logic [20:0] CLK_LINE_MAP = {3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
  // Secondary lines that reach the control mux
  localparam logic [14:0] CTL_LINE_MAP = {3'h7, 3'h3, 3'h2, 3'h1, 3'h0};
  // Output of an unselected slice mux
  localparam logic MUX_DEFAULT = 1'b1;
  // Level of a region line with no source picked
  localparam logic LINE_IDLE = 1'b0;

  // Per region line selection
  typedef struct packed {
    logic [7:0] line_en;
    logic [7:0][2:0] line_src;
  } scs_region_cfg_t;

  // Per slice selection
  typedef struct packed {
    logic [4:0] clk_sel;
    logic [2:0] ce_sel;
    logic [2:0] lsr_sel;
  } scs_slice_cfg_t;

  // Whole configuration image
  typedef struct packed {
    logic [7:0] global_en;
    scs_region_cfg_t [19:0] region;
    scs_slice_cfg_t [19:0][2:0] slice;
  } scs_cfg_t;

  // What one slice receives
  typedef struct packed {
    logic clk;
    logic ce;
    logic local_set_reset;
  } scs_slice_out_t;
endpackage
`default_nettype wire

/* scs_secondary_clock_select.sv */
`default_nettype none
module scs_secondary_clock_select (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration load
  input wire logic cfg_load,
  input wire scs_pkg::scs_cfg_t cfg_in,
  output logic cfg_loaded,
  // Secondary source inputs
  input wire logic [5:0] pad_src,
  input wire logic [1:0] routed_src,
  // Fabric signals offered to the slices
  input wire logic [7:0] primary_clk,
  input wire logic [19:0][2:0] route_clk,
  input wire logic [19:0][2:0] route_ce,
  input wire logic [19:0][2:0] route_lsr,
  // Distributed results
  output logic [19:0][7:0] region_line,
  output scs_pkg::scs_slice_out_t [19:0][2:0] slice_out
);

  // All state of the block
  typedef struct packed {
    logic [5:0] pad_meta;
    logic [5:0] pad_sync;
    logic loaded;
    scs_pkg::scs_cfg_t cfg;
    logic [19:0][7:0] region_line;
    scs_pkg::scs_slice_out_t [19:0][2:0] slice_out;
  } scs_state_t;

  scs_state_t st; // Registered state
  scs_state_t next_st; // Next state
  logic [7:0] src; // The eight secondary sources

  // Slice clock mux; only seven secondary lines are wired in
  function automatic logic clk_pick(input logic [4:0] sel, input logic [7:0] pri,
                                    input logic [7:0] lines, input logic route);
    logic [4:0] idx;
    idx = '0;
    clk_pick = scs_pkg::MUX_DEFAULT;
    if (sel >= scs_pkg::CLK_SEL_PRI0 && sel < scs_pkg::CLK_SEL_SEC0) begin
      idx = sel - scs_pkg::CLK_SEL_PRI0;
      clk_pick = pri[idx[2:0]];
    end else if (sel >= scs_pkg::CLK_SEL_SEC0 && sel < scs_pkg::CLK_SEL_ROUTE) begin
      idx = sel - scs_pkg::CLK_SEL_SEC0;
      clk_pick = lines[scs_pkg::CLK_LINE_MAP[idx*3 +: 3]];
    end else if (sel == scs_pkg::CLK_SEL_ROUTE) begin
      clk_pick = route;
    end
  endfunction

  // Slice control mux, shared by clock enable and set/reset
  function automatic logic ctl_pick(input logic [2:0] sel, input logic [7:0] lines,
                                    input logic route);
    logic [2:0] idx;
    idx = '0;
    ctl_pick = scs_pkg::MUX_DEFAULT;
    if (sel >= scs_pkg::CTL_SEL_SEC0 && sel < scs_pkg::CTL_SEL_ROUTE) begin
      idx = sel - scs_pkg::CTL_SEL_SEC0;
      ctl_pick = lines[scs_pkg::CTL_LINE_MAP[idx*3 +: 3]];
    end else if (sel == scs_pkg::CTL_SEL_ROUTE) begin
      ctl_pick = route;
    end
  endfunction

  // Six synchronised pads, then two sources from general routing
  assign src = {routed_src, st.pad_sync};

  // Next state
  always_comb begin
    next_st = st;
    // Pads are asynchronous to ref_clk, two flops before use
    next_st.pad_meta = pad_src;
    next_st.pad_sync = st.pad_meta;
    // Configuration is taken once; later loads are ignored
    if (cfg_load && !st.loaded) begin
      next_st.cfg = cfg_in;
      next_st.loaded = 1'b1;
    end
    // Region muxes: every region sees all eight sources
    for (int r = 0; r < scs_pkg::NUM_REGION; r++) begin
      for (int k = 0; k < scs_pkg::NUM_SRC; k++) begin
        if (st.cfg.global_en[k]) begin
          // A global line bypasses the per region choice
          next_st.region_line[r][k] = src[k];
        end else if (st.cfg.region[r].line_en[k]) begin
          next_st.region_line[r][k] = src[st.cfg.region[r].line_src[k]];
        end else begin
          next_st.region_line[r][k] = scs_pkg::LINE_IDLE;
        end
      end
    end
    // Slice muxes; slice 3 holds no registers so has none
    for (int r = 0; r < scs_pkg::NUM_REGION; r++) begin
      for (int s = 0; s < scs_pkg::NUM_SLICE; s++) begin
        next_st.slice_out[r][s].clk = clk_pick(st.cfg.slice[r][s].clk_sel, primary_clk,
                                               st.region_line[r], route_clk[r][s]);
        // Control reuses the clock lines of the region
        next_st.slice_out[r][s].ce = ctl_pick(st.cfg.slice[r][s].ce_sel,
                                              st.region_line[r], route_ce[r][s]);
        next_st.slice_out[r][s].local_set_reset = ctl_pick(st.cfg.slice[r][s].lsr_sel,
                                                           st.region_line[r], route_lsr[r][s]);
      end
    end
  end

  // State register; an unconfigured slice sees ones
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.slice_out <= '1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign cfg_loaded = st.loaded;
  assign region_line = st.region_line;
  assign slice_out = st.slice_out;

  // Checks, all in the ref_clk domain
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Pad level walks through both sync flops
  sequence seq_pad_rise;
    pad_src[0] ##2 st.pad_sync[0];
  endsequence
  AST_PAD_SYNC: assert property (pad_src[0] |-> seq_pad_rise)
    else $error("pad not seen two cycles later");

  // A global line follows its own source in the last region
  AST_GLOBAL_LINE: assert property (st.cfg.global_en[3] |=> region_line[19][3] == $past(src[3]))
    else $error("global line missing in region");

  // Region line follows the source chosen for it
  AST_REGION_PICK: assert property (!st.cfg.global_en[6] && st.cfg.region[0].line_en[6]
    |=> region_line[0][6] == $past(src[st.cfg.region[0].line_src[6]]))
    else $error("region line not from chosen source");

  // Configuration does not move once loaded
  AST_CFG_STATIC: assert property (st.loaded |=> $stable(st.cfg) && st.loaded)
    else $error("configuration changed after load");

  // Unselected muxes drive one
  AST_CLK_DEFAULT: assert property (st.cfg.slice[0][0].clk_sel == scs_pkg::CLK_SEL_NONE
    |=> slice_out[0][0].clk)
    else $error("idle clock mux not one");
  AST_CE_DEFAULT: assert property (st.cfg.slice[4][2].ce_sel == scs_pkg::CTL_SEL_NONE
    |=> slice_out[4][2].ce)
    else $error("idle control mux not one");

  // Line 7 serves the control mux through code five
  AST_CTL_LINE7: assert property (st.cfg.slice[0][1].lsr_sel == 3'h5
    |=> slice_out[0][1].local_set_reset == $past(st.region_line[0][7]))
    else $error("control not from line 7");

  // Line 0 serves the clock mux through the first secondary code
  AST_CLK_LINE0: assert property (st.cfg.slice[1][0].clk_sel == scs_pkg::CLK_SEL_SEC0
    |=> slice_out[1][0].clk == $past(st.region_line[1][0]))
    else $error("clock not from line 0");

  // Primary clock and routed clock reach the slice
  AST_CLK_PRIMARY: assert property (st.cfg.slice[2][2].clk_sel == scs_pkg::CLK_SEL_PRI0
    |=> slice_out[2][2].clk == $past(primary_clk[0]))
    else $error("clock not from primary 0");
  AST_CLK_ROUTE: assert property (st.cfg.slice[3][1].clk_sel == scs_pkg::CLK_SEL_ROUTE
    |=> slice_out[3][1].clk == $past(route_clk[3][1]))
    else $error("clock not from routing");

  // Source chain from pad to slice, four cycles in all
  sequence seq_chain_cfg;
    st.cfg.global_en[4] && st.cfg.slice[5][0].clk_sel == 5'h0c;
  endsequence
  AST_PAD_TO_SLICE: assert property (seq_chain_cfg [*5] ##0 $past(pad_src[4], 4)
    |-> slice_out[5][0].clk)
    else $error("pad 4 did not reach slice clock");

  // Routed source 7 reaches a set/reset input over the line, two cycles
  sequence seq_routed_cfg;
    st.cfg.global_en[7] && st.cfg.slice[14][1].lsr_sel == 3'h5;
  endsequence
  AST_ROUTED_TO_SLICE: assert property (seq_routed_cfg [*3] ##0 $past(routed_src[1], 2)
    |-> slice_out[14][1].local_set_reset)
    else $error("routed source 7 did not reach set/reset");

  // A low pad level also walks through both sync flops
  AST_SYNC_FALL: assert property (!pad_src[5] |-> ##2 !st.pad_sync[5])
    else $error("pad low not seen two cycles later");

  // Routed sources sit behind the pads, unsynchronised
  AST_ROUTED_LINE: assert property (st.cfg.global_en[6]
    |=> region_line[10][6] == $past(routed_src[0]))
    else $error("routed source 6 missing on its line");

  // Global line 0 in the first region
  AST_GLOBAL_FIRST: assert property (st.cfg.global_en[0]
    |=> region_line[0][0] == $past(src[0]))
    else $error("global line 0 missing in region 0");

  // A line with no enable and no global stays idle
  AST_REGION_IDLE: assert property (!st.cfg.global_en[2] && !st.cfg.region[13].line_en[2]
    |=> region_line[13][2] == scs_pkg::LINE_IDLE)
    else $error("unselected region line not idle");

  // Region pick in the last region as well
  AST_REGION_PICK_LAST: assert property (!st.cfg.global_en[1] && st.cfg.region[19].line_en[1]
    |=> region_line[19][1] == $past(src[st.cfg.region[19].line_src[1]]))
    else $error("last region line not from chosen source");

  // A configuration offered before any load is taken at once
  AST_LOAD_TAKE: assert property (cfg_load && !cfg_loaded
    |=> cfg_loaded && st.cfg == $past(cfg_in))
    else $error("configuration not taken");

  // Loaded flag never drops outside reset
  AST_LOADED_STICKY: assert property (cfg_loaded |=> cfg_loaded)
    else $error("loaded flag dropped");

  // Routed clock enable and set/reset
  AST_CE_ROUTE: assert property (st.cfg.slice[6][0].ce_sel == scs_pkg::CTL_SEL_ROUTE
    |=> slice_out[6][0].ce == $past(route_ce[6][0]))
    else $error("enable not from routing");
  AST_LSR_ROUTE: assert property (st.cfg.slice[7][2].lsr_sel == scs_pkg::CTL_SEL_ROUTE
    |=> slice_out[7][2].local_set_reset == $past(route_lsr[7][2]))
    else $error("set/reset not from routing");

  // Unused and idle codes give one
  AST_LSR_DEFAULT: assert property (st.cfg.slice[8][1].lsr_sel == scs_pkg::CTL_SEL_NONE
    |=> slice_out[8][1].local_set_reset)
    else $error("idle set/reset mux not one");
  AST_CLK_HIGH_CODE: assert property (st.cfg.slice[9][0].clk_sel > scs_pkg::CLK_SEL_ROUTE
    |=> slice_out[9][0].clk)
    else $error("unused clock code not one");
  AST_CTL_CODE7: assert property (st.cfg.slice[10][1].ce_sel == 3'h7
    |=> slice_out[10][1].ce)
    else $error("unused control code not one");

  // Control lines 0 and 3
  AST_CTL_LINE0: assert property (st.cfg.slice[16][0].ce_sel == scs_pkg::CTL_SEL_SEC0
    |=> slice_out[16][0].ce == $past(st.region_line[16][0]))
    else $error("enable not from line 0");
  AST_CTL_LINE3: assert property (st.cfg.slice[11][2].ce_sel == 3'h4
    |=> slice_out[11][2].ce == $past(st.region_line[11][3]))
    else $error("enable not from line 3");

  // Line 7 serves clock enable too
  AST_CE_LINE7: assert property (st.cfg.slice[17][1].ce_sel == 3'h5
    |=> slice_out[17][1].ce == $past(st.region_line[17][7]))
    else $error("enable not from line 7");

  // Set/reset from line 1
  AST_LSR_LINE1: assert property (st.cfg.slice[18][2].lsr_sel == 3'h2
    |=> slice_out[18][2].local_set_reset == $past(st.region_line[18][1]))
    else $error("set/reset not from line 1");

  // Clock lines 1, 2, 4 and 7
  AST_CLK_LINE1: assert property (st.cfg.slice[19][0].clk_sel == 5'h0a
    |=> slice_out[19][0].clk == $past(st.region_line[19][1]))
    else $error("clock not from line 1");
  AST_CLK_LINE2: assert property (st.cfg.slice[13][1].clk_sel == 5'h0b
    |=> slice_out[13][1].clk == $past(st.region_line[13][2]))
    else $error("clock not from line 2");
  AST_CLK_LINE4: assert property (st.cfg.slice[15][2].clk_sel == 5'h0c
    |=> slice_out[15][2].clk == $past(st.region_line[15][4]))
    else $error("clock not from line 4");
  AST_CLK_LINE7: assert property (st.cfg.slice[12][0].clk_sel == 5'h0f
    |=> slice_out[12][0].clk == $past(st.region_line[12][7]))
    else $error("clock not from line 7");

  // Last primary clock code
  AST_PRIMARY_LAST: assert property (st.cfg.slice[0][2].clk_sel == 5'h08
    |=> slice_out[0][2].clk == $past(primary_clk[7]))
    else $error("clock not from primary 7");

endmodule
`default_nettype wire

/* scs_slice_model.sv */
`default_nettype none
// Slice flops: toggle on enable, cleared by set/reset
module scs_slice_model (
  // Clock
  input wire logic ref_clk,
  // Mux results
  input wire scs_pkg::scs_slice_out_t [19:0][2:0] slice_out,
  // Flop states
  output logic [19:0][2:0] q
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sampled as data, so a glitchy mux cannot race the flops
  always_ff @(posedge ref_clk) begin
    for (int r = 0; r < 20; r++) begin
      for (int s = 0; s < 3; s++) begin
        q[r][s] <= slice_out[r][s].local_set_reset ? 1'b0 : q[r][s] ^ slice_out[r][s].ce;
      end
    end
  end
endmodule
`default_nettype wire

/* secondary_clock_select_tb_top.sv */
`default_nettype none
module secondary_clock_select_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Stimulus and results
  logic ref_clk, rst, cfg_load, cfg_loaded;
  scs_pkg::scs_cfg_t cfg, cfg_in;
  logic [5:0] pad_src;
  logic [1:0] routed_src;
  logic [7:0] primary_clk;
  logic [19:0][2:0] route_clk, route_ce, route_lsr, q;
  logic [19:0][7:0] region_line;
  scs_pkg::scs_slice_out_t [19:0][2:0] slice_out;
  int seed = 32'h8623;
  int n_fail = 0;
  int num_checks = 0;
  // Expected line k of region r; global overrides region pick
  function automatic logic exp_line(int r, int k);
    logic [7:0] src;
    src = {routed_src, pad_src};
    if (cfg.global_en[k]) return src[k];
    if (cfg.region[r].line_en[k]) return src[cfg.region[r].line_src[k]];
    return scs_pkg::LINE_IDLE;
  endfunction
  function automatic logic [7:0] exp_lines(int r);
    logic [7:0] v;
    for (int k = 0; k < 8; k++) v[k] = exp_line(r, k);
    return v;
  endfunction
  // Control mux; unused codes give one
  function automatic logic ctl(logic [2:0] sel, logic [7:0] ln, logic rt);
    if (sel inside {[3'h1:3'h5]}) return ln[scs_pkg::CTL_LINE_MAP[3*(sel-1) +: 3]];
    return (sel == 3'h6) ? rt : scs_pkg::MUX_DEFAULT;
  endfunction
  // Expected {clk, ce, local_set_reset} of one slice
  function automatic logic [2:0] exp_slice(int r, int s);
    scs_pkg::scs_slice_cfg_t c;
    logic [7:0] ln;
    logic [2:0] o;
    c = cfg.slice[r][s];
    ln = exp_lines(r);
    o = 3'h7;
    if (c.clk_sel inside {[5'h01:5'h08]}) o[2] = primary_clk[c.clk_sel - 5'h01];
    if (c.clk_sel inside {[5'h09:5'h0f]}) o[2] = ln[scs_pkg::CLK_LINE_MAP[3*(c.clk_sel-9) +: 3]];
    if (c.clk_sel == 5'h10) o[2] = route_clk[r][s];
    o[1] = ctl(c.ce_sel, ln, route_ce[r][s]);
    o[0] = ctl(c.lsr_sel, ln, route_lsr[r][s]);
    return o;
  endfunction
  task automatic check(string nm, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Fresh random sources and routed signals
  task automatic drive_random();
    pad_src = 6'($random(seed));
    routed_src = 2'($random(seed));
    primary_clk = 8'($random(seed));
    route_clk = 60'({$random(seed), $random(seed)});
    route_ce = 60'({$random(seed), $random(seed)});
    route_lsr = 60'({$random(seed), $random(seed)});
  endtask
  // Let pad sync and both mux stages settle, then compare all
  task automatic check_all();
    repeat (5) @(negedge ref_clk);
    for (int r = 0; r < 20; r++) begin
      check("region_line", exp_lines(r), region_line[r]);
      for (int s = 0; s < 3; s++) check("slice_out", 8'(exp_slice(r, s)), 8'(slice_out[r][s]));
      // A slice held in set/reset must show a cleared flop
      for (int s = 0; s < 3; s++) if (exp_slice(r, s) & 3'h1) check("slice q", 8'h00, 8'(q[r][s]));
    end
  endtask
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  scs_secondary_clock_select u_dut (.ref_clk(ref_clk), .rst(rst), .cfg_load(cfg_load), .cfg_in(cfg_in),
    .cfg_loaded(cfg_loaded), .pad_src(pad_src), .routed_src(routed_src), .primary_clk(primary_clk),
    .route_clk(route_clk), .route_ce(route_ce), .route_lsr(route_lsr), .region_line(region_line),
    .slice_out(slice_out));
  scs_slice_model u_slices (.ref_clk(ref_clk), .slice_out(slice_out), .q(q));
  // Main sequence: one reset and one image per pass
  initial begin
    cfg_load = 1'b0;
    cfg = '0;
    cfg_in = '0;
    drive_random();
    for (int i = 0; i < 4; i++) begin
      rst = 1'b1;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      check("cfg_loaded", 8'h00, 8'(cfg_loaded));
      check("reset line", 8'h00, region_line[3]);
      check("reset slice", 8'h07, 8'(slice_out[3][1]));
      for (int j = 0; j < 41; j++) cfg = scs_pkg::scs_cfg_t'({cfg[$bits(cfg)-33:0], $random(seed)});
      // Pass 0 sweeps every select code; pass 1 makes all lines global
      if (i == 0) begin
        cfg.global_en = 8'h00;
        for (int r = 0; r < 20; r++) begin
          for (int s = 0; s < 3; s++) cfg.slice[r][s] = {5'(r*3+s), 3'(r*3+s), 3'(r*3+s+2)};
        end
      end
      if (i == 1) begin
        // Corner selects so the guarded paths are exercised
        cfg.global_en = 8'hff;
        cfg.slice[5][0].clk_sel = 5'h0c;
        cfg.slice[4][2].ce_sel = 3'h0;
        cfg.slice[0][1].lsr_sel = 3'h5;
        cfg.slice[1][0].clk_sel = 5'h09;
        cfg.slice[2][2].clk_sel = 5'h01;
        cfg.slice[3][1].clk_sel = 5'h10;
        cfg.slice[14][1].lsr_sel = 3'h5;
      end
      rst = 1'b0;
      cfg_in = cfg;
      cfg_load = 1'b1;
      @(negedge ref_clk);
      // A second image offered while loaded must be ignored
      cfg_in = ~cfg;
      check("cfg_loaded", 8'h01, 8'(cfg_loaded));
      @(negedge ref_clk);
      cfg_load = 1'b0;
      repeat (3) begin
        drive_random();
        check_all();
      end
      if (i == 1) begin
        routed_src = ~routed_src;
        pad_src = ~pad_src;
        @(negedge ref_clk);
        check("routed line", 8'(exp_line(7, 7)), 8'(region_line[7][7]));
        @(negedge ref_clk);
        check("pad line early", {7'h00, !exp_line(7, 4)}, 8'(region_line[7][4]));
        @(negedge ref_clk);
        check("pad line", 8'(exp_line(7, 4)), 8'(region_line[7][4]));
      end
    end
    tally_and_finish();
  end
  // Watchdog, far beyond the hundred or fewer cycles needed
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
